// ===== src/esld_pkg.sv
// package of constants and carrier types for the ethernet status led driver
package esld_pkg;
  // system clock rate and period
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // blink half period in milliseconds, count derived from the clock rate
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;
  // sync depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;
  // reset value of every indicator (dark)
  localparam logic LED_OFF = 1'b1;
  localparam logic LED_ON = 1'b0;

  // status levels reported by the phy
  typedef struct packed {
    logic collision;
    logic link_up;
    logic rx_active;
    logic tx_active;
    logic full_duplex;
    logic speed_100;
  } esld_phy_status_t;

  // active-low indicator outputs
  typedef struct packed {
    logic collision_indicator_n;
    logic link_activity_indicator_n;
    logic duplex_indicator_n;
    logic speed_indicator_n;
    logic receive_activity_indicator_n;
  } esld_leds_t;
endpackage

// ===== src/esld_blink_gen.sv
// free-running divider producing the blink phase
`timescale 1ns/1ps
`default_nettype none
module esld_blink_gen #(
  parameter int unsigned HALF_CYC = 1000000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // blink phase level and toggle pulse
  output logic phase_o,
  output logic tick_o
);
  localparam int unsigned CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

  logic [CW-1:0] cnt;

  // count half periods and flip the phase at each wrap
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= '0;
      phase_o <= 1'b0;
      tick_o <= 1'b0;
    end else if (cnt == LAST) begin
      cnt <= '0;
      phase_o <= ~phase_o;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== src/esld_led_driver.sv
// ethernet status led driver top: phy status to active-low leds
`timescale 1ns/1ps
`default_nettype none
module esld_led_driver
  import esld_pkg::*;
#(
  parameter int unsigned BLINK_HALF = esld_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // phy status levels, asynchronous to sys_clk_i
  input wire esld_pkg::esld_phy_status_t phy_status_i,
  // led pins
  output esld_pkg::esld_leds_t leds_o
);
  import esld_pkg::*;

  typedef enum logic [2:0] {
    ESLD_DOWN = 3'b001,
    ESLD_IDLE = 3'b010,
    ESLD_BUSY = 3'b100
  } esld_link_state_t;

  esld_phy_status_t sync1;
  esld_phy_status_t sync2;
  esld_link_state_t link_state;
  esld_link_state_t next_link_state;
  logic phase;
  logic tick;
  // one flop per led pin, packed onto leds_o below
  logic coll_n;
  logic link_n;
  logic duplex_n;
  logic speed_n;
  logic rx_n;

  // all checks run on the system clock, quiet in reset except a_reset_dark
  default clocking esld_chk_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // two-flop synchroniser on all phy status inputs
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= phy_status_i;
      sync2 <= sync1;
    end
  end

  esld_blink_gen #(
    .HALF_CYC(BLINK_HALF)
  ) u_blink (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .phase_o(phase),
    .tick_o(tick)
  );

  // link state decode
  always_comb begin
    next_link_state = ESLD_DOWN;
    if (sync2.link_up && (sync2.rx_active || sync2.tx_active)) begin
      next_link_state = ESLD_BUSY;
    end else if (sync2.link_up) begin
      next_link_state = ESLD_IDLE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_state <= ESLD_DOWN;
    end else begin
      link_state <= next_link_state;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      coll_n <= LED_OFF;
    end else begin
      coll_n <= ~sync2.collision;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_n <= LED_OFF;
    end else begin
      case (link_state)
        ESLD_DOWN: begin
          link_n <= LED_OFF;
        end
        ESLD_IDLE: begin
          link_n <= LED_ON;
        end
        ESLD_BUSY: begin
          link_n <= phase;
        end
        default: begin
          link_n <= LED_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      duplex_n <= LED_OFF;
      speed_n <= LED_OFF;
    end else begin
      duplex_n <= ~sync2.full_duplex;
      speed_n <= ~sync2.speed_100;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_n <= LED_OFF;
    end else if (sync2.rx_active) begin
      rx_n <= phase;
    end else begin
      rx_n <= LED_OFF;
    end
  end

  // pins straight from the led flops, one driver for the port
  assign leds_o = '{
    collision_indicator_n: coll_n,
    link_activity_indicator_n: link_n,
    duplex_indicator_n: duplex_n,
    speed_indicator_n: speed_n,
    receive_activity_indicator_n: rx_n
  };

  // checks
  // collision led tracks
  a_coll_follows: assert property (
    ##1 leds_o.collision_indicator_n == !$past(sync2.collision))
    else $error("collision led does not follow collision");

  a_link_down_dark: assert property (
    !sync2.link_up [*3] |-> leds_o.link_activity_indicator_n)
    else $error("link_activity_indicator_n lit while link down");

  a_link_idle_lit: assert property (
    (sync2.link_up && !sync2.rx_active && !sync2.tx_active) [*3]
    |-> !leds_o.link_activity_indicator_n)
    else $error("link_activity_indicator_n dark while link idle");

  a_link_blinks: assert property (
    (sync2.link_up && (sync2.rx_active || sync2.tx_active)) [*3]
    |-> leds_o.link_activity_indicator_n == $past(phase))
    else $error("link_activity_indicator_n not blinking in activity");

  a_busy_on_link: assert property (
    link_state == ESLD_BUSY
    |-> $past(sync2.link_up && (sync2.rx_active || sync2.tx_active)))
    else $error("link busy without link and activity");

  a_duplex_led: assert property (
    ##1 leds_o.duplex_indicator_n == !$past(sync2.full_duplex))
    else $error("duplex led wrong");

  a_speed_led: assert property (
    ##1 leds_o.speed_indicator_n == !$past(sync2.speed_100))
    else $error("speed led wrong");

  a_rx_blink: assert property (
    ##1 leds_o.receive_activity_indicator_n ==
    ($past(sync2.rx_active) ? $past(phase) : 1'b1))
    else $error("receive led wrong");

  a_phase_toggle: assert property (
    tick |-> phase != $past(phase))
    else $error("blink phase did not toggle on tick");

  a_phase_hold: assert property (
    !tick |-> phase == $past(phase))
    else $error("blink phase moved without tick");

  a_reset_dark: assert property (disable iff (1'b0)
    !rst_b_i ##1 !rst_b_i |-> leds_o == '1)
    else $error("led lit during reset");

  // main scenarios worth reaching
  c_collision: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !leds_o.collision_indicator_n);
  c_link_blink: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    link_state == ESLD_BUSY && tick);
  c_link_idle: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    link_state == ESLD_IDLE);
  c_rx_blink: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    sync2.rx_active && tick);
  c_link_down: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    link_state == ESLD_DOWN);
endmodule
`default_nettype wire

// ===== tb/esld_led_model.sv
// board led model: active-low pins to lit flags
`timescale 1ns/1ps
`default_nettype none
module esld_led_model
  import esld_pkg::*;
(
  // led pins from the driver
  input wire esld_pkg::esld_leds_t leds_i,
  // lit flags, one per led
  output logic [4:0] lit_o
);
  // an led lights while its pin is low
  assign lit_o = ~leds_i;
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the status led driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import esld_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  esld_phy_status_t phy_status_i = '0;
  esld_leds_t leds_o;
  logic [4:0] lit;
  logic [9:0] note_q[$];
  int mismatches = 0;
  int checked = 0;

  // clock, 50 ns period
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  esld_led_driver #(.BLINK_HALF(4)) dut (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .phy_status_i(phy_status_i),
    .leds_o(leds_o)
  );

  esld_led_model led (.leds_i(leds_o), .lit_o(lit));

  // compare and count
  task automatic check(input logic [4:0] got, input logic [4:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic print_verdict();
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // driver: random status levels, expected lit and blink notes
  initial begin
    esld_phy_status_t s;
    logic [4:0] exp;
    logic [4:0] blk;
    void'($urandom(32'hee9188d8));
    repeat (20) @(posedge sys_clk_i);
    check(lit, 5'h00);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    repeat (40) begin
      s = esld_phy_status_t'(6'($urandom));
      phy_status_i <= s;
      blk = {1'b0, s.link_up & (s.rx_active | s.tx_active), 3'b000};
      blk[0] = s.rx_active;
      exp = {s.collision, s.link_up, s.full_duplex, s.speed_100, 1'b0};
      exp = exp | blk;
      repeat (6) @(posedge sys_clk_i);
      note_q.push_back({exp, blk});
      repeat (12) @(posedge sys_clk_i);
    end
    // reset in mid-run darkens every led at once
    phy_status_i <= 6'h33;
    repeat (5) @(posedge sys_clk_i);
    #1 check(lit, 5'h1e);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    #1 check(lit, 5'h00);
    repeat (3) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    #1 check(lit, 5'h00);
    repeat (3) @(posedge sys_clk_i);
    #1 check(lit, 5'h1e);
    print_verdict();
  end

  // monitor: oldest note against ten cycles of leds
  initial begin
    logic [9:0] n;
    logic [4:0] l0;
    logic [4:0] tog;
    logic [4:0] obs;
    forever begin
      @(posedge sys_clk_i);
      if (note_q.size() > 0) begin
        n = note_q.pop_front();
        #1 l0 = lit;
        tog = '0;
        repeat (10) begin
          @(posedge sys_clk_i);
          #1 tog = tog | (lit ^ l0);
        end
        // blinking leds must change, steady ones must not
        for (int i = 0; i < 5; i++) begin
          obs[i] = n[i] ? tog[i] : (tog[i] ? 1'bx : l0[i]);
        end
        check(obs, n[9:5]);
      end
    end
  end

  // watchdog against a hang
  initial begin
    repeat (2000) @(posedge sys_clk_i);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
